// File: dv/rtcs_i2c_master.sv
`timescale 1ns/100ps
// Two-wire bus master model; the clock stands still between frames
module rtcs_i2c_master (
   input wire logic i_sys_clk,
   input wire logic i_sda_line,
   output logic o_scl,
   output logic o_sda_low
);
   // Bus idle: both lines released high
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // Quarter of the 80 ns link period, landing on falling system edges
   task automatic q();
      repeat (5) @(negedge i_sys_clk);
   endtask
   // START, also a repeated start from a low clock; waits first so the device lets go
   task automatic start();
      q();
      o_sda_low = 1'b0;
      q();
      o_scl = 1'b1;
      q();
      o_sda_low = 1'b1;
      q();
      o_scl = 1'b0;
   endtask
   // STOP, then a bus-free gap before any new START
   task automatic stop();
      q();
      o_sda_low = 1'b1;
      q();
      o_scl = 1'b1;
      q();
      o_sda_low = 1'b0;
      q();
      q();
   endtask
   // One bit: data moves only in the low half, read back mid high half
   task automatic bit_io(input logic b, output logic r);
      q();
      o_sda_low = ~b;
      q();
      o_scl = 1'b1;
      q();
      r = i_sda_line;
      q();
      o_scl = 1'b0;
   endtask
   // Eight bits MSB first, then the acknowledge pulse; ack_in low means ACK
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic ack_out);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ack_in, a);
      ack_out = ~a;
   endtask
endmodule

// File: dv/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_wr_ready = 1'b0;
   logic scl, m_low, sda_line, o_sda, o_sda_oe_n, o_wr_valid, o_busy, ack, drv, drv_q;
   rtcs_pkg::rtcs_wr_s o_wr;
   rtcs_pkg::rtcs_wr_s exp_w;
   rtcs_pkg::rtcs_wr_s wq[$];
   logic [7:0] o_rd_addr, i_rd_data, rx, ptr, rb;
   logic [7:0] regs [256];
   logic [7:0] ref_mem [256];
   logic [7:0] bad [4] = '{8'hd0, 8'h53, 8'hd7, 8'h92};
   logic [15:0] seed = 16'he23;
   int errors = 0;
   int total_checks = 0;

   always #2 i_sys_clk = ~i_sys_clk;
   // Open-drain data line with pull-up: anyone pulling low wins
   assign drv = ~o_sda_oe_n & ~o_sda;
   assign sda_line = ~(m_low | drv);
   assign i_rd_data = regs[o_rd_addr];

   rtcs_slave rtcs_slave_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_scl(scl),
      .i_sda(sda_line), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_wr_valid(o_wr_valid),
      .i_wr_ready(i_wr_ready), .o_wr(o_wr), .o_rd_addr(o_rd_addr), .i_rd_data(i_rd_data),
      .o_busy(o_busy));
   rtcs_i2c_master rtcs_i2c_master_inst (.i_sys_clk(i_sys_clk), .i_sda_line(sda_line),
      .o_scl(scl), .o_sda_low(m_low));

   // Register space stores accepted writes; each is matched to the oldest note
   always @(posedge i_sys_clk) begin
      drv_q <= drv;
      if (scl === 1'b1 && i_rst_n === 1'b1) `CHK("sda steady", drv_q, drv)
      if (o_wr_valid === 1'b1 && i_wr_ready === 1'b1) begin
         regs[o_wr.addr] <= o_wr.data;
         exp_w = (wq.size() > 0) ? wq.pop_front() : 16'hxxxx;
         `CHK("write", exp_w, o_wr)
      end
   end

   // Sixteen-bit LFSR for data and stall patterns
   function automatic logic [7:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction

   task automatic wbyte(input logic [7:0] b, input logic exp_ack);
      rtcs_i2c_master_inst.xfer(b, 1'b1, rx, ack);
      `CHK("ack", exp_ack, ack)
   endtask
   // Master reads one byte; only the last one is left unacknowledged
   task automatic rbyte(input logic [7:0] exp, input logic last);
      rtcs_i2c_master_inst.xfer(8'hff, last, rx, ack);
      `CHK("read", exp, rx)
   endtask
   // Address for write, offset, then n data bytes noted as expected writes
   task automatic wr_seq(input logic [7:0] off, input int n);
      logic [7:0] d;
      rtcs_i2c_master_inst.start();
      wbyte({rtcs_pkg::SLAVE_ADDR, 1'b0}, 1'b1);
      wbyte(off, 1'b1);
      ptr = off;
      for (int i = 0; i < n; i++) begin
         d = rnd();
         wq.push_back({ptr, d});
         ref_mem[ptr] = d;
         wbyte(d, 1'b1);
         ptr++;
      end
   endtask
   task automatic rd_seq(input int n);
      wbyte({rtcs_pkg::SLAVE_ADDR, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) begin
         rbyte(ref_mem[ptr], i == n - 1);
         ptr++;
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge i_sys_clk);
      errors++;
      $display("MISMATCH timeout exp done got hang");
      close_out();
   end

   initial begin
      for (int i = 0; i < 256; i++) begin
         regs[i] = i[7:0] ^ 8'h3c;
         ref_mem[i] = i[7:0] ^ 8'h3c;
      end
      repeat (8) @(negedge i_sys_clk);
      `CHK("reset oe_n", 1'b1, o_sda_oe_n)
      `CHK("reset busy", 1'b0, o_busy)
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      // Other addresses, both directions, get no acknowledge
      foreach (bad[i]) begin
         rtcs_i2c_master_inst.start();
         wbyte(bad[i], 1'b0);
         rtcs_i2c_master_inst.stop();
      end
      $display("test foreign addresses done");
      // Burst across the pointer wrap while the register space stalls
      wr_seq(8'hfc, rtcs_pkg::WQ_DEPTH);
      `CHK("busy", 1'b1, o_busy)
      rtcs_i2c_master_inst.stop();
      `CHK("idle", 1'b0, o_busy)
      for (int i = 0; i < 400 && wq.size() > 0; i++) begin
         rb = rnd();
         i_wr_ready = rb[0];
         @(negedge i_sys_clk);
      end
      i_wr_ready = 1'b1;
      `CHK("drained", 0, wq.size())
      $display("test burst write done");
      // Offset load, repeated start, read across the wrap
      wr_seq(8'hfe, 0);
      rtcs_i2c_master_inst.start();
      rd_seq(3);
      rtcs_i2c_master_inst.stop();
      `CHK("pointer", ptr, o_rd_addr)
      // New read continues from the kept pointer
      rtcs_i2c_master_inst.start();
      rd_seq(2);
      rtcs_i2c_master_inst.stop();
      $display("test reads done");
      // Write, then offset load closed by STOP, then a fresh START to read
      wr_seq(8'h40, 2);
      rtcs_i2c_master_inst.stop();
      wr_seq(8'h40, 0);
      rtcs_i2c_master_inst.stop();
      rtcs_i2c_master_inst.start();
      rd_seq(2);
      rtcs_i2c_master_inst.stop();
      $display("test stop start read done");
      `CHK("drained", 0, wq.size())
      close_out();
   end
endmodule

// File: rtl/rtcs_fifo.sv
`timescale 1ns/100ps
module rtcs_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("rtcs_fifo depth must be a power of two, at least 2");
      end
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;

   // Extra pointer bit separates full from empty
   assign o_in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign o_out_valid = wr_q != rd_q;
   assign o_out_data = mem_q[rd_q[AW-1:0]];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   // Storage
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= i_in_data;
      end
   end

   // Pointers
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule

// File: rtl/rtcs_pkg.sv
package rtcs_pkg;

   // Bus address of this slave on the two-wire link
   localparam logic [6:0] SLAVE_ADDR = 7'h69;
   // Offset and data widths, pointer reset value and step
   localparam int PTR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [7:0] PTR_STEP = 8'h01;
   // Bit counter limits within one byte
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   // The clock's first fall after START closes the START and is not a bit,
   // so the counter starts one below zero and wraps to zero on that fall
   localparam logic [3:0] BIT_PRE = 4'hf;
   // Read bit driven after the first fall inside a byte
   localparam logic [3:0] BIT_LAST_M1 = 4'h6;
   // Write queue depth
   localparam int WQ_DEPTH = 8;

   // Protocol phases of the slave
   typedef enum logic [2:0] {
      RTCS_IDLE,
      RTCS_ADDR,
      RTCS_ADDR_ACK,
      RTCS_RX,
      RTCS_RX_ACK,
      RTCS_TX,
      RTCS_TX_ACK
   } rtcs_state_e;

   // One register write passed to the register space
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } rtcs_wr_s;

endpackage

// File: rtl/rtcs_slave.sv
`timescale 1ns/100ps
// Overview of operation
// - Data falling while clock high is a START.
// - Data rising while clock high is a STOP.
// - A START before a STOP acts as STOP then START.
// - Data changes only while clock low; one bit per clock pulse.
// - Eight-bit bytes, each followed by a ninth acknowledge pulse.
// - No limit on bytes between START and STOP.
// - Answer address 1101001 with ACK; eighth bit zero write, one read.
// - Any other address gets no acknowledge.
// - Addressed device acknowledges every byte it receives.
// - Acknowledger holds data low for whole acknowledge clock high.
// - Master NAKs last byte; device then releases the data line.
// - First byte after write address loads the address pointer.
// - Further write bytes store at pointer, then pointer advances.
// - Writes continue into consecutive registers until STOP.
// - After read address, send register at pointer, then advance.
// - Keep sending until NAK, STOP or repeated START.
// - Pointer keeps its value between transfers.
module rtcs_slave (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   output logic o_wr_valid,
   input wire logic i_wr_ready,
   output rtcs_pkg::rtcs_wr_s o_wr,
   output logic [7:0] o_rd_addr,
   input wire logic [7:0] i_rd_data,
   output logic o_busy
);
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   rtcs_pkg::rtcs_state_e state_q;
   logic [3:0] bit_q;
   logic [7:0] shift_q;
   logic [7:0] ptr_q;
   logic have_ptr_q;
   logic drive_low_q;
   logic wq_valid_q;
   logic wq_ready;
   rtcs_pkg::rtcs_wr_s wq_data_q;
   rtcs_pkg::rtcs_wr_s fifo_out;
   logic fifo_valid;
   logic ack_is_low;
   logic [7:0] rx_byte;

   // Two flops on each pin before anything looks at it
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], i_scl};
         sda_sync_q <= {sda_sync_q[0], i_sda};
         scl_q <= scl_sync_q[1];
         sda_q <= sda_sync_q[1];
      end
   end

   // Edges and bus conditions from the synchronised levels
   assign scl_rise = scl_sync_q[1] && !scl_q;
   assign scl_fall = !scl_sync_q[1] && scl_q;
   assign start_det = scl_sync_q[1] && scl_q && sda_q && !sda_sync_q[1];
   assign stop_det = scl_sync_q[1] && scl_q && !sda_q && sda_sync_q[1];
   assign rx_byte = {shift_q[6:0], sda_sync_q[1]};
   assign ack_is_low = !sda_sync_q[1];

   // Protocol state; START always restarts, so a repeat START acts as STOP+START
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_q <= rtcs_pkg::RTCS_IDLE;
         bit_q <= rtcs_pkg::BIT_ZERO;
         shift_q <= '0;
         have_ptr_q <= 1'b0;
      end else if (start_det) begin
         state_q <= rtcs_pkg::RTCS_ADDR;
         bit_q <= rtcs_pkg::BIT_PRE;
         have_ptr_q <= 1'b0;
      end else if (stop_det) begin
         state_q <= rtcs_pkg::RTCS_IDLE;
      end else if (scl_rise) begin
         // Sample on the rising edge: data is stable while the clock is high
         case (state_q)
            rtcs_pkg::RTCS_ADDR, rtcs_pkg::RTCS_RX: begin
               shift_q <= rx_byte;
            end
            rtcs_pkg::RTCS_TX_ACK: begin
               if (!ack_is_low) begin
                  state_q <= rtcs_pkg::RTCS_IDLE;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state_q)
            rtcs_pkg::RTCS_ADDR: begin
               if (bit_q == rtcs_pkg::BIT_LAST) begin
                  bit_q <= rtcs_pkg::BIT_ZERO;
                  if (shift_q[7:1] == rtcs_pkg::SLAVE_ADDR) begin
                     state_q <= rtcs_pkg::RTCS_ADDR_ACK;
                  end else begin
                     state_q <= rtcs_pkg::RTCS_IDLE;
                  end
               end else begin
                  bit_q <= bit_q + 4'h1;
               end
            end
            rtcs_pkg::RTCS_ADDR_ACK: begin
               state_q <= shift_q[0] ? rtcs_pkg::RTCS_TX : rtcs_pkg::RTCS_RX;
            end
            rtcs_pkg::RTCS_RX: begin
               if (bit_q == rtcs_pkg::BIT_LAST) begin
                  bit_q <= rtcs_pkg::BIT_ZERO;
                  state_q <= rtcs_pkg::RTCS_RX_ACK;
               end else begin
                  bit_q <= bit_q + 4'h1;
               end
            end
            rtcs_pkg::RTCS_RX_ACK: begin
               have_ptr_q <= 1'b1;
               state_q <= rtcs_pkg::RTCS_RX;
            end
            rtcs_pkg::RTCS_TX: begin
               if (bit_q == rtcs_pkg::BIT_LAST) begin
                  bit_q <= rtcs_pkg::BIT_ZERO;
                  state_q <= rtcs_pkg::RTCS_TX_ACK;
               end else begin
                  bit_q <= bit_q + 4'h1;
               end
            end
            rtcs_pkg::RTCS_TX_ACK: begin
               state_q <= rtcs_pkg::RTCS_TX;
            end
            default: begin
               state_q <= rtcs_pkg::RTCS_IDLE;
            end
         endcase
      end
   end

   // Pointer survives STOP and START; only loads and increments move it
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         ptr_q <= rtcs_pkg::PTR_RST;
      end else if (scl_fall && state_q == rtcs_pkg::RTCS_RX_ACK) begin
         if (!have_ptr_q) begin
            ptr_q <= shift_q;
         end else begin
            ptr_q <= ptr_q + rtcs_pkg::PTR_STEP;
         end
      end else if (scl_fall && state_q == rtcs_pkg::RTCS_TX && bit_q == rtcs_pkg::BIT_LAST) begin
         ptr_q <= ptr_q + rtcs_pkg::PTR_STEP;
      end
   end

   // Data pin: ACK low during ack slots, else shift read data MSB first on clock low
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         drive_low_q <= 1'b0;
      end else if (start_det || stop_det) begin
         drive_low_q <= 1'b0;
      end else if (scl_fall) begin
         case (state_q)
            rtcs_pkg::RTCS_ADDR: begin
               drive_low_q <= bit_q == rtcs_pkg::BIT_LAST
                  && shift_q[7:1] == rtcs_pkg::SLAVE_ADDR;
            end
            rtcs_pkg::RTCS_RX: begin
               drive_low_q <= bit_q == rtcs_pkg::BIT_LAST;
            end
            rtcs_pkg::RTCS_ADDR_ACK: begin
               drive_low_q <= shift_q[0] && !i_rd_data[7];
            end
            rtcs_pkg::RTCS_TX: begin
               drive_low_q <= bit_q != rtcs_pkg::BIT_LAST
                  && !i_rd_data[3'(rtcs_pkg::BIT_LAST_M1 - bit_q)];
            end
            rtcs_pkg::RTCS_TX_ACK: begin
               drive_low_q <= !ack_is_low ? 1'b0 : !i_rd_data[7];
            end
            default: begin
               drive_low_q <= 1'b0;
            end
         endcase
      end
   end
   // Completed write bytes queue toward the register space; with the queue full a byte
   // waits in one holding register and is lost if the next byte completes first, since the two-wire slave cannot stretch the clock here
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         wq_valid_q <= 1'b0;
         wq_data_q <= '0;
      end else if (scl_fall && state_q == rtcs_pkg::RTCS_RX_ACK && have_ptr_q) begin
         wq_valid_q <= 1'b1;
         wq_data_q <= '{addr: ptr_q, data: shift_q};
      end else if (wq_ready) begin
         wq_valid_q <= 1'b0;
      end
   end

   rtcs_fifo #(
      .WIDTH(16),
      .DEPTH(rtcs_pkg::WQ_DEPTH)
   ) u_wq (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_in_valid(wq_valid_q),
      .o_in_ready(wq_ready),
      .i_in_data(wq_data_q),
      .o_out_valid(fifo_valid),
      .i_out_ready(i_wr_ready && !(o_wr_valid && i_wr_ready)),
      .o_out_data(fifo_out)
   );

   // Output stage registered so every output is a flop
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_wr_valid <= 1'b0;
         o_wr <= '0;
         o_sda <= 1'b1;
         o_sda_oe_n <= 1'b1;
         o_rd_addr <= rtcs_pkg::PTR_RST;
         o_busy <= 1'b0;
      end else begin
         if (o_wr_valid && i_wr_ready) begin
            o_wr_valid <= 1'b0;
         end else if (!o_wr_valid && fifo_valid && i_wr_ready) begin
            o_wr_valid <= 1'b1;
            o_wr <= fifo_out;
         end
         o_sda <= 1'b0;
         o_sda_oe_n <= !drive_low_q;
         o_rd_addr <= ptr_q;
         o_busy <= state_q != rtcs_pkg::RTCS_IDLE;
      end
   end

   a_stop_idles: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      stop_det && !start_det |=> state_q == rtcs_pkg::RTCS_IDLE)
      else $error("stop did not idle");
   a_start_addr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      start_det |=> state_q == rtcs_pkg::RTCS_ADDR && bit_q == rtcs_pkg::BIT_PRE)
      else $error("start did not begin address phase");
   a_addr_nak: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      scl_fall && state_q == rtcs_pkg::RTCS_ADDR && bit_q == 4'h7
      && shift_q[7:1] != 7'h69 && !start_det && !stop_det |=> !drive_low_q)
      else $error("foreign address acknowledged");
   a_addr_ack: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      scl_fall && state_q == rtcs_pkg::RTCS_ADDR && bit_q == 4'h7
      && shift_q[7:1] == 7'h69 && !start_det && !stop_det |=> drive_low_q ##2 !o_sda_oe_n)
      else $error("own address not acknowledged");
   a_rx_ack: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      state_q == rtcs_pkg::RTCS_RX_ACK && scl_sync_q[1] && scl_q |-> drive_low_q)
      else $error("received byte not acknowledged");
   a_ptr_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      scl_fall && state_q == rtcs_pkg::RTCS_RX_ACK && !have_ptr_q && !start_det && !stop_det
      |=> ptr_q == $past(shift_q))
      else $error("offset not loaded");
   a_ptr_inc: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      scl_fall && state_q == rtcs_pkg::RTCS_TX && bit_q == 4'h7 && !start_det && !stop_det
      |=> ptr_q == $past(ptr_q) + 8'h01)
      else $error("pointer did not advance on read");
   a_nak_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      scl_rise && state_q == rtcs_pkg::RTCS_TX_ACK && !ack_is_low && !start_det && !stop_det
      |=> state_q == rtcs_pkg::RTCS_IDLE ##1 !drive_low_q [*2])
      else $error("data line not released after nak");
   a_ptr_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      start_det |=> ptr_q == $past(ptr_q))
      else $error("pointer changed by start");
   // The master needs a free line for its own acknowledge after bit 0
   a_tx_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      scl_fall && state_q == rtcs_pkg::RTCS_TX && bit_q == 4'h7 && !start_det && !stop_det
      |=> !drive_low_q)
      else $error("data line not released for master acknowledge");
   a_ptr_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      scl_fall && state_q == rtcs_pkg::RTCS_RX_ACK && have_ptr_q && ptr_q == 8'hff
      && !start_det && !stop_det |=> ptr_q == 8'h00)
      else $error("pointer did not wrap to zero");
   // A stalled register space must see the same write until it takes it
   a_wr_stands: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr))
      else $error("write request dropped before taken");
   a_pin_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      drive_low_q |=> !o_sda_oe_n)
      else $error("data pin not pulled while driving low");
endmodule
